// file: apt_axil_slave.sv
/*
 AXI4-Lite slave front end: takes one write and one read at a time.
 Assumes register decode and read mux sit in the parent.
*/
`timescale 1ns/1ps
`include "apt_regs.svh"
module apt_axil_slave (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axil_awaddr,
   input  wire logic              s_axil_awvalid,
   output logic                   s_axil_awready,
   input  wire logic [31:0]       s_axil_wdata,
   input  wire logic [3:0]        s_axil_wstrb,
   input  wire logic              s_axil_wvalid,
   output logic                   s_axil_wready,
   output logic [1:0]             s_axil_bresp,
   output logic                   s_axil_bvalid,
   input  wire logic              s_axil_bready,
   input  wire logic              s_axil_arvalid,
   output logic                   s_axil_arready,
   output logic [31:0]            s_axil_rdata,
   output logic [1:0]             s_axil_rresp,
   output logic                   s_axil_rvalid,
   input  wire logic              s_axil_rready,
   output logic                   wr_en,   // Write pulse
   output logic [7:0]             wr_addr, // Held write address
   output logic [31:0]            wr_data, // Held write data
   output logic [3:0]             wr_strb, // Held byte strobes
   input  wire logic              wr_err,  // Write address unmapped
   input  wire logic [31:0]       rd_data, // Mux of araddr
   input  wire logic              rd_err   // Read address unmapped
);
   // Both halves held and no response outstanding
   assign wr_en = !s_axil_awready && !s_axil_wready && !s_axil_bvalid;

   // Address and data taken independently, ready dropped while held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_awready <= 1'b1;
         s_axil_wready  <= 1'b1;
         wr_addr        <= 8'h00;
         wr_data        <= 32'h0000_0000;
         wr_strb        <= 4'h0;
      end else begin
         if (s_axil_awvalid && s_axil_awready) begin
            s_axil_awready <= 1'b0;
            wr_addr        <= s_axil_awaddr;
         end
         if (s_axil_wvalid && s_axil_wready) begin
            s_axil_wready <= 1'b0;
            wr_data       <= s_axil_wdata;
            wr_strb       <= s_axil_wstrb;
         end
         // Reopen only once the response has been taken
         if (s_axil_bvalid && s_axil_bready) begin
            s_axil_awready <= 1'b1;
            s_axil_wready  <= 1'b1;
         end
      end
   end

   // Write response one cycle after the write pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_bvalid <= 1'b0;
         s_axil_bresp  <= `APT_RESP_OKAY;
      end else if (wr_en) begin
         s_axil_bvalid <= 1'b1;
         s_axil_bresp  <= wr_err ? `APT_RESP_SLVERR : `APT_RESP_OKAY;
      end else if (s_axil_bready) begin
         s_axil_bvalid <= 1'b0;
      end
   end

   // Read data captured in the cycle the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_arready <= 1'b1;
         s_axil_rvalid  <= 1'b0;
         s_axil_rdata   <= 32'h0000_0000;
         s_axil_rresp   <= `APT_RESP_OKAY;
      end else if (s_axil_arvalid && s_axil_arready) begin
         s_axil_arready <= 1'b0;
         s_axil_rvalid  <= 1'b1;
         s_axil_rdata   <= rd_data;
         s_axil_rresp   <= rd_err ? `APT_RESP_SLVERR : `APT_RESP_OKAY;
      end else if (s_axil_rvalid && s_axil_rready) begin
         s_axil_arready <= 1'b1;
         s_axil_rvalid  <= 1'b0;
      end
   end
endmodule : apt_axil_slave

// file: apt_core_model.sv
/*
 Stand-in for the shared conversion core: one done pulse per start.
 Assumes starts come one at a time from the pair control block.
*/
`timescale 1ns/1ps
module apt_core_model #(
   parameter int DLY = 20 // Busy span in cycles
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic conv_start_r,
   output logic      conv_done
);
   int cnt_r; // Cycles left, zero when idle
   ////////////////////////////////////////////////
   // Long busy span so that other pairs must queue behind it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r     <= 0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= (cnt_r == 1);
         if (conv_start_r && cnt_r == 0) cnt_r <= DLY;
         else if (cnt_r != 0) cnt_r <= cnt_r - 1;
      end
   end
endmodule : apt_core_model

// file: apt_pair_trig_ctrl.sv
/*
 Converter pair trigger control: six pairs, three pair control
 registers, a sticky completion status with mask, and a one-at-a-time
 request port to the shared conversion core.
 Assumes trigger inputs are one-cycle pulses synchronous to aclk and
 that the core pulses conv_done once per conv_start.
*/
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "apt_regs.svh"
module apt_pair_trig_ctrl (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axil_awaddr,
   input  wire logic        s_axil_awvalid,
   output logic             s_axil_awready,
   input  wire logic [31:0] s_axil_wdata,
   input  wire logic [3:0]  s_axil_wstrb,
   input  wire logic        s_axil_wvalid,
   output logic             s_axil_wready,
   output logic [1:0]       s_axil_bresp,
   output logic             s_axil_bvalid,
   input  wire logic        s_axil_bready,
   input  wire logic [7:0]  s_axil_araddr,
   input  wire logic        s_axil_arvalid,
   output logic             s_axil_arready,
   output logic [31:0]      s_axil_rdata,
   output logic [1:0]       s_axil_rresp,
   output logic             s_axil_rvalid,
   input  wire logic        s_axil_rready,
   input  wire logic        glob_sw_trig,   // Global software trigger
   input  wire logic        pwm_spec_trig,  // Primary special event
   input  wire logic        pwm_sspec_trig, // Secondary special event
   input  wire logic [7:0]  pwm_prim_trig,  // Generators 1-8 primary
   input  wire logic [8:0]  pwm_sec_trig,   // Generators 1-9 second.
   input  wire logic [7:0]  pwm_clim_trig,  // Generators 1-8 cur-lim
   input  wire logic        first_timer_pm, // First timer period
   input  wire logic        second_timer_pm,// Second timer period
   output logic             conv_start_r,   // Core request pulse
   output logic [2:0]       conv_pair_r,    // Pair being converted
   output logic [3:0]       conv_chan_hi_r, // Odd channel
   output logic [3:0]       conv_chan_lo_r, // Even channel
   input  wire logic        conv_done,      // Core finished pulse
   output logic             irq_r           // Level interrupt
);
   import apt_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic [5:0]    irqen_r;         // Per-pair interrupt enable
   logic [5:0]    pend_r;          // Per-pair pending flag
   logic [5:0]    swt_r;           // Per-pair software trigger
   apt_sel_type   sel_r [6];       // Per-pair source code
   logic [5:0]    stat_r;          // Sticky completion status
   logic [5:0]    mask_r;          // Interrupt mask
   logic [5:0]    issued_r;        // Pending already sent to core
   apt_state_type state_r;         // Core ownership
   logic [5:0]    hit;             // Selected trigger fired
   logic [5:0]    done_p;          // This pair just completed
   logic [5:0]    pend_nxt;
   logic [5:0]    swt_nxt;
   logic [5:0]    stat_nxt;
   logic [5:0]    wsel;            // Byte of this pair written
   logic [7:0]    pbyte [6];       // Read view of each pair
   logic [7:0]    wbyte [6];       // Write data of each pair
   logic          wr_en;
   logic [7:0]    wr_addr;
   logic [31:0]   wr_data;
   logic [3:0]    wr_strb;
   logic          wr_err;
   logic [31:0]   rd_data;
   logic          rd_err;
   logic          wr_stat;         // Status clear write
   logic          wr_mask;         // Mask write
   logic [5:0]    ready;           // Pending but not yet sent
   logic [2:0]    grant;           // Lowest ready pair
   logic          grant_v;

   ////////////////////////////////////////////////////////////////////
   // Bus front end
   apt_axil_slave u_bus (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .s_axil_awaddr  (s_axil_awaddr),
      .s_axil_awvalid (s_axil_awvalid),
      .s_axil_awready (s_axil_awready),
      .s_axil_wdata   (s_axil_wdata),
      .s_axil_wstrb   (s_axil_wstrb),
      .s_axil_wvalid  (s_axil_wvalid),
      .s_axil_wready  (s_axil_wready),
      .s_axil_bresp   (s_axil_bresp),
      .s_axil_bvalid  (s_axil_bvalid),
      .s_axil_bready  (s_axil_bready),
      .s_axil_arvalid (s_axil_arvalid),
      .s_axil_arready (s_axil_arready),
      .s_axil_rdata   (s_axil_rdata),
      .s_axil_rresp   (s_axil_rresp),
      .s_axil_rvalid  (s_axil_rvalid),
      .s_axil_rready  (s_axil_rready),
      .wr_en          (wr_en),
      .wr_addr        (wr_addr),
      .wr_data        (wr_data),
      .wr_strb        (wr_strb),
      .wr_err         (wr_err),
      .rd_data        (rd_data),
      .rd_err         (rd_err)
   );

   assign wr_stat = wr_en && wr_addr == `APT_OFF_STAT && wr_strb[0];
   assign wr_mask = wr_en && wr_addr == `APT_OFF_MASK && wr_strb[0];
   assign wr_err  = wr_addr > `APT_OFF_MASK || wr_addr[1:0] != 2'h0;

   ////////////////////////////////////////////////////////////////////
   // Per-pair trigger, pending, software bit and status next values
   for (genvar i = 0; i < `APT_NPAIRS; i++) begin : g_pair
      localparam int R = i / 2; // Register holding this pair
      localparam int B = i % 2; // Byte: odd pair in the upper one
      localparam logic [7:0] OFF = 8'(R * `APT_PC_STRIDE);

      apt_trig_sel u_sel (
         .sel      (sel_r[i]),
         .sw_bit   (swt_r[i]),
         .glob_sw  (glob_sw_trig),
         .spec     (pwm_spec_trig),
         .sec_spec (pwm_sspec_trig),
         .prim     (pwm_prim_trig),
         .sec      (pwm_sec_trig),
         .clim     (pwm_clim_trig),
         .tmr1     (first_timer_pm),
         .tmr2     (second_timer_pm),
         .hit      (hit[i])
      );

      assign wsel[i]  = wr_en && wr_addr == `APT_OFF_PC01 + OFF &&
                        wr_strb[B];
      assign wbyte[i] = wr_data[8*B +: 8];
      assign pbyte[i] = {irqen_r[i], pend_r[i], swt_r[i], sel_r[i]};
      assign done_p[i] = conv_done && state_r == APT_BUSY &&
                         conv_pair_r == 3'(i);
      // A new trigger wins over a completion in the same cycle
      assign pend_nxt[i] = hit[i] | (pend_r[i] & ~done_p[i]);
      // Cleared as pending rises or re-arms on completion, so a held
      // bit cannot loop conversions; a fresh write still lands
      assign swt_nxt[i] = wsel[i] ? wbyte[i][`APT_BIT_SWT] :
         (swt_r[i] & ~(hit[i] & (~pend_r[i] | done_p[i])));
      // Set wins over a write-one-to-clear in the same cycle
      assign stat_nxt[i] = (done_p[i] & irqen_r[i]) |
         (stat_r[i] & ~(wr_stat & wr_data[i]));
   end

   ////////////////////////////////////////////////////////////////////
   // Pair control fields written by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irqen_r <= 6'h00;
         for (int k = 0; k < `APT_NPAIRS; k++) begin
            sel_r[k] <= apt_sel_type'(`APT_RST_PC);
         end
      end else begin
         for (int k = 0; k < `APT_NPAIRS; k++) begin
            if (wsel[k]) begin
               irqen_r[k] <= wbyte[k][`APT_BIT_IRQEN];
               sel_r[k]   <= wbyte[k][`APT_SEL_MSB:0];
            end
         end
      end
   end

   // Pending flags, software bits and status; pending is read-only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_r <= 6'h00;
         swt_r  <= 6'h00;
         stat_r <= `APT_RST_STAT;
      end else begin
         pend_r <= pend_nxt;
         swt_r  <= swt_nxt;
         stat_r <= stat_nxt;
      end
   end

   // Mask register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= `APT_RST_MASK;
      end else if (wr_mask) begin
         mask_r <= wr_data[5:0];
      end
   end

   // Interrupt level from flops only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_nxt & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Core arbitration: lowest pending pair first, one at a time
   assign ready = pend_r & ~issued_r;
   always_comb begin
      grant   = 3'h0;
      grant_v = 1'b0;
      for (int k = `APT_NPAIRS - 1; k >= 0; k--) begin
         if (ready[k]) begin
            grant   = 3'(k);
            grant_v = 1'b1;
         end
      end
   end

   // Request stays pending while the core is busy with another pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r        <= APT_IDLE;
         conv_start_r   <= 1'b0;
         conv_pair_r    <= 3'h0;
         conv_chan_hi_r <= 4'h0;
         conv_chan_lo_r <= 4'h0;
      end else begin
         conv_start_r <= 1'b0;
         unique case (state_r)
            APT_IDLE: begin
               if (grant_v) begin
                  state_r        <= APT_BUSY;
                  conv_start_r   <= 1'b1;
                  conv_pair_r    <= grant;
                  conv_chan_hi_r <= {grant, 1'b1};
                  conv_chan_lo_r <= {grant, 1'b0};
               end
            end
            APT_BUSY: begin
               if (conv_done) begin
                  state_r <= APT_IDLE;
               end
            end
         endcase
      end
   end

   // Sent marks; a retrigger on completion makes the pair ready again
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         issued_r <= 6'h00;
      end else begin
         for (int k = 0; k < `APT_NPAIRS; k++) begin
            if (done_p[k]) begin
               issued_r[k] <= 1'b0;
            end else if (state_r == APT_IDLE && grant_v && grant == 3'(k))
            begin
               issued_r[k] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (s_axil_araddr)
         `APT_OFF_PC01: rd_data[15:0] = {pbyte[1], pbyte[0]};
         `APT_OFF_PC23: rd_data[15:0] = {pbyte[3], pbyte[2]};
         `APT_OFF_PC45: rd_data[15:0] = {pbyte[5], pbyte[4]};
         `APT_OFF_STAT: rd_data[5:0]  = stat_r;
         `APT_OFF_MASK: rd_data[5:0]  = mask_r;
         default:       rd_err        = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [5:0] pend_d_r; // Pending one cycle ago
   logic [5:0] wsw_d_r;  // Software bit written one cycle ago
   always_ff @(posedge aclk) begin
      pend_d_r <= pend_r;
      wsw_d_r  <= wsel & {wbyte[5][5], wbyte[4][5], wbyte[3][5],
                          wbyte[2][5], wbyte[1][5], wbyte[0][5]};
   end

   property p_pend_set;
      |(hit & ~pend_r) |=> |(pend_r & ~pend_d_r);
   endproperty
   a_pend_set: assert property (p_pend_set)
      else $error("pending did not set on trigger");

   property p_pend_clr;
      (state_r == APT_BUSY && conv_done && !hit[conv_pair_r])
      |=> !pend_r[$past(conv_pair_r)];
   endproperty
   a_pend_clr: assert property (p_pend_clr)
      else $error("pending did not clear on completion");

   property p_swt_clr;
      !(|(pend_r & ~pend_d_r & swt_r & ~wsw_d_r));
   endproperty
   a_swt_clr: assert property (p_swt_clr)
      else $error("software bit survived pending set");

   property p_sw_start;
      (swt_r[1] && sel_r[1] == 5'h01 && !pend_r[1]) |=> pend_r[1];
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("software bit did not start pair 1");

   property p_off;
      (sel_r[0] == 5'h00 && !pend_r[0]) |=> !pend_r[0];
   endproperty
   a_off: assert property (p_off)
      else $error("disabled pair went pending");

   property p_irq_req;
      (state_r == APT_BUSY && conv_done && irqen_r[conv_pair_r]
       && mask_r[conv_pair_r]) |=> irq_r ##0 stat_r[$past(conv_pair_r)];
   endproperty
   a_irq_req: assert property (p_irq_req)
      else $error("no interrupt on enabled completion");

   property p_no_irq;
      (stat_r == 6'h00 && !(state_r == APT_BUSY && conv_done
       && irqen_r[conv_pair_r])) |=> stat_r == 6'h00;
   endproperty
   a_no_irq: assert property (p_no_irq)
      else $error("status set without enabled completion");

   property p_hold;
      (state_r == APT_BUSY && !conv_done) |=> !conv_start_r;
   endproperty
   a_hold: assert property (p_hold)
      else $error("second request while core busy");

   property p_chan;
      conv_start_r |-> conv_chan_hi_r == {conv_pair_r, 1'b1} &&
         conv_chan_lo_r == {conv_pair_r, 1'b0} && pend_r[conv_pair_r];
   endproperty
   a_chan: assert property (p_chan)
      else $error("wrong channels for pair");

   property p_rd_map;
      (s_axil_arvalid && s_axil_arready && s_axil_araddr == 8'h00)
      |=> s_axil_rdata[14] == $past(pend_r[1]) &&
          s_axil_rdata[6] == $past(pend_r[0]);
   endproperty
   a_rd_map: assert property (p_rd_map)
      else $error("pair byte placement wrong");

   c_start: cover property (conv_start_r);
   c_queue: cover property (state_r == APT_BUSY && |ready);
   c_irq:   cover property ($rose(irq_r));
   c_retrg: cover property (|(done_p & hit));
endmodule : apt_pair_trig_ctrl

// file: apt_pair_trig_ctrl_tb.sv
/*
 Self-checking bench for the pair trigger control block.
 Assumes apt_core_model answers each start after a fixed delay.
*/
`timescale 1ns/1ps
module apt_pair_trig_ctrl_tb;
   logic        aclk, aresetn, s_axil_awvalid, s_axil_awready;
   logic [7:0]  s_axil_awaddr, s_axil_araddr;
   logic [31:0] s_axil_wdata, s_axil_rdata;
   logic [3:0]  s_axil_wstrb, conv_chan_hi_r, conv_chan_lo_r;
   logic [1:0]  s_axil_bresp, s_axil_rresp;
   logic        s_axil_wvalid, s_axil_wready, s_axil_bvalid, s_axil_bready;
   logic        s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
   logic        glob_sw_trig, pwm_spec_trig, pwm_sspec_trig;
   logic        first_timer_pm, second_timer_pm, conv_start_r, conv_done;
   logic [7:0]  pwm_prim_trig, pwm_clim_trig;
   logic [8:0]  pwm_sec_trig;
   logic [2:0]  conv_pair_r;
   logic        irq_r;
   int          bad_count, num_checks, nstart; // Tallies
   ////////////////////////////////////////////////
   apt_pair_trig_ctrl dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
      .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
      .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
      .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
      .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .glob_sw_trig,
      .pwm_spec_trig, .pwm_sspec_trig, .pwm_prim_trig, .pwm_sec_trig,
      .pwm_clim_trig, .first_timer_pm, .second_timer_pm, .conv_start_r,
      .conv_pair_r, .conv_chan_hi_r, .conv_chan_lo_r, .conv_done, .irq_r);
   apt_core_model core (.aclk, .aresetn, .conv_start_r, .conv_done);
   // Clock and start counter
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) if (conv_start_r) nstart++;
   ////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axil_awaddr <= a;
      s_axil_wdata <= d;
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid <= 1'b1;
      s_axil_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axil_awready) s_axil_awvalid <= 1'b0;
         if (s_axil_wready) s_axil_wvalid <= 1'b0;
      end while (!s_axil_bvalid && n < 100);
      s_axil_bready <= 1'b0;
      chk({31'h0, s_axil_bvalid}, 32'h1);
      chk({30'h0, s_axil_bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axil_arready) s_axil_arvalid <= 1'b0;
      end while (!s_axil_rvalid && n < 100);
      s_axil_rready <= 1'b0;
      chk({31'h0, s_axil_rvalid}, 32'h1);
      chk(s_axil_rdata, exp);
      chk({30'h0, s_axil_rresp}, {30'h0, er});
   endtask : rd
   // One-cycle pulse on the source of code c; code 0 pulses every source
   task automatic pulse(input int c);
      @(posedge aclk);
      glob_sw_trig <= c == 0 || c == 2;
      pwm_spec_trig <= c == 0 || c == 3;
      first_timer_pm <= c == 0 || c == 12;
      pwm_sspec_trig <= c == 0 || c == 13;
      second_timer_pm <= c == 0 || c == 31;
      pwm_prim_trig <= (c == 0) ? 8'hFF : 8'(c inside {[4:11]}) << (c - 4);
      pwm_sec_trig <= (c == 0) ? 9'h1FF : 9'(c inside {[14:22]}) << (c - 14);
      pwm_clim_trig <= (c == 0) ? 8'hFF : 8'(c inside {[23:30]}) << (c - 23);
      @(posedge aclk);
      {glob_sw_trig, pwm_spec_trig, first_timer_pm, pwm_sspec_trig} <= '0;
      {second_timer_pm, pwm_prim_trig, pwm_sec_trig, pwm_clim_trig} <= '0;
   endtask : pulse
   // Wait for a start and check pair and channel numbers
   task automatic wstart(input logic [2:0] p);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!conv_start_r && n < 100);
      chk({31'h0, conv_start_r}, 32'h1);
      chk({29'h0, conv_pair_r}, {29'h0, p});
      chk({24'h0, conv_chan_hi_r, conv_chan_lo_r}, {24'h0, p, 1'b1, p, 1'b0});
   endtask : wstart
   task automatic wdone;
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!conv_done && n < 100);
      chk({31'h0, conv_done}, 32'h1);
      @(posedge aclk);
   endtask : wdone
   ////////////////////////////////////////////////
   initial begin
      #400000;
      bad_count++;
      final_report();
   end
   initial begin
      {aresetn, s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
      {s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
      {s_axil_arvalid, s_axil_rready, glob_sw_trig, pwm_spec_trig} = '0;
      {pwm_sspec_trig, first_timer_pm, second_timer_pm, pwm_prim_trig} = '0;
      {pwm_sec_trig, pwm_clim_trig, bad_count, num_checks, nstart} = '0;
      s_axil_wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 20; a += 4) rd(8'(a), 32'h0, 2'h0);
      rd(8'h14, 32'h0, 2'h2);
      wr(8'h14, 32'h1, 2'h2);
      wr(8'h00, 32'h20, 2'h0);
      pulse(0);
      repeat (10) @(posedge aclk);
      chk(nstart, 0);
      for (int c = 3; c < 32; c++) begin
         wr(8'h00, 32'(c), 2'h0);
         pulse(c);
         wstart(3'd0);
         wdone();
      end
      chk(nstart, 29);
      wr(8'h00, 32'h2100, 2'h0);
      wstart(3'd1);
      rd(8'h00, 32'h4100, 2'h0);
      wdone();
      rd(8'h00, 32'h0100, 2'h0);
      rd(8'h0C, 32'h0, 2'h0);
      wr(8'h04, 32'hA1, 2'h0);
      wstart(3'd2);
      wdone();
      rd(8'h0C, 32'h4, 2'h0);
      chk({31'h0, irq_r}, 32'h0);
      wr(8'h10, 32'h4, 2'h0);
      // Interrupt follows the mask one edge after the write lands
      @(posedge aclk);
      chk({31'h0, irq_r}, 32'h1);
      wr(8'h0C, 32'h4, 2'h0);
      chk({31'h0, irq_r}, 32'h0);
      wr(8'h04, 32'h0200, 2'h0);
      wr(8'h08, 32'h0200, 2'h0);
      pulse(2);
      wstart(3'd3);
      wstart(3'd5);
      wdone();
      final_report();
   end
endmodule : apt_pair_trig_ctrl_tb

// file: apt_pkg.sv
/*
 Types shared by the pair trigger control block.
 Assumes apt_regs.svh supplies the numeric constants.
*/
package apt_pkg;
   // Conversion core ownership
   typedef enum logic {APT_IDLE, APT_BUSY} apt_state_type;
   // Trigger source selection code
   typedef logic [4:0] apt_sel_type;
endpackage : apt_pkg

// file: apt_regs.svh
/*
 Register offsets, field positions, reset values and widths of the
 pair trigger control block.
 Assumes a 32-bit AXI4-Lite slave with byte addresses on 8 bits.
*/
`ifndef APT_REGS_SVH
`define APT_REGS_SVH
`define APT_NPAIRS      6
`define APT_AW          8
`define APT_OFF_PC01    8'h00
`define APT_OFF_PC23    8'h04
`define APT_OFF_PC45    8'h08
`define APT_OFF_STAT    8'h0C
`define APT_OFF_MASK    8'h10
`define APT_PC_STRIDE   8'h04
`define APT_BIT_IRQEN   7
`define APT_BIT_PEND    6
`define APT_BIT_SWT     5
`define APT_SEL_MSB     4
`define APT_RST_PC      16'h0000
`define APT_RST_STAT    6'h00
`define APT_RST_MASK    6'h00
`define APT_RESP_OKAY   2'h0
`define APT_RESP_SLVERR 2'h2
`endif

// file: apt_trig_sel.sv
/*
 Trigger source multiplexer for one converter pair.
 Assumes all trigger inputs are one-cycle pulses on aclk.
*/
`timescale 1ns/1ps
module apt_trig_sel (
   input  wire apt_pkg::apt_sel_type sel,      // Source code
   input  wire logic                 sw_bit,   // Own software bit
   input  wire logic                 glob_sw,  // Global software
   input  wire logic                 spec,     // Primary special evt
   input  wire logic                 sec_spec, // Secondary special
   input  wire logic [7:0]           prim,     // Primary triggers
   input  wire logic [8:0]           sec,      // Secondary triggers
   input  wire logic [7:0]           clim,     // Current-limit trig
   input  wire logic                 tmr1,     // First timer period
   input  wire logic                 tmr2,     // Second timer period
   output logic                      hit       // Selected trigger
);
   import apt_pkg::*;
   logic [31:0] src; // One bit per code, bit 0 always dead

   // Code 2 also honours the own bit, so software that selects the
   // global code before setting it still gets its conversion
   assign src = {tmr2, clim, sec, sec_spec, tmr1, prim, spec,
                 glob_sw | sw_bit, sw_bit, 1'b0};
   // Codes 4-11, 14-22, 23-30 map in ascending order, 12 and 31 timers
   assign hit = src[sel];
endmodule : apt_trig_sel
